// *** hdl/abs_cmd_consts.vh ***
// Constants for the abstract command decoder: offsets, field positions,
// reset values and error codes shared by the field check and the decoder.
// Assumes it is included by bare name from files under hdl/.
`ifndef ABS_CMD_CONSTS_VH
`define ABS_CMD_CONSTS_VH

// Debug module interface word offsets
`define ACW_OFF_FIRST_DATA_WORD 7'h04
`define ACW_OFF_SECOND_DATA_WORD 7'h05
`define ACW_OFF_ABSCS 7'h16
`define ACW_OFF_CMD 7'h17

// Command word field positions
`define ACW_KIND_MSB 31
`define ACW_KIND_LSB 24
`define ACW_VIRT_BIT 23
`define ACW_SIZE_MSB 22
`define ACW_SIZE_LSB 20
`define ACW_POSTINC_BIT 19
`define ACW_POSTEXEC_BIT 18
`define ACW_XFER_BIT 17
`define ACW_WRITE_BIT 16
`define ACW_REGNO_MSB 15
`define ACW_REGNO_LSB 0

// Command field encodings
`define ACW_KIND_REG 8'h00
`define ACW_KIND_MEM 8'h02
`define ACW_SIZE_32 3'h2
`define ACW_REGNO_GPR_LO 16'h1000
`define ACW_REGNO_GPR_HI 16'h101F
`define ACW_REGNO_GPR_BIT 12

// Command word reset values of the readable fields
`define ACW_SIZE_RST 3'h2
`define ACW_XFER_RST 1'b1

// Error codes
`define ACW_ERR_NONE 3'h0
`define ACW_ERR_BUSY 3'h1
`define ACW_ERR_NOTSUP 3'h2
`define ACW_ERR_EXCEPT 3'h3

// Control and status word layout
`define ACW_CS_BUSY_BIT 12
`define ACW_CS_ERR_MSB 10
`define ACW_CS_ERR_LSB 8
`define ACW_CS_DATACOUNT 4'h2

`endif

// *** hdl/cmd_field_check.v ***
// Combinational check of a latched abstract command word.
// Assumes the word is stable while the caller samples the outputs.
`default_nettype none
`include "abs_cmd_consts.vh"

module cmd_field_check (
  input wire [31:0] cmd_word,      // Latched command word
  output reg is_reg,               // Register access kind
  output reg is_mem,               // Memory access kind
  output reg do_xfer,              // Data movement wanted
  output reg [2:0] err_code        // Field error, zero when clean
);

  wire [7:0] kind = cmd_word[`ACW_KIND_MSB:`ACW_KIND_LSB];
  wire size_ok = (cmd_word[`ACW_SIZE_MSB:`ACW_SIZE_LSB] == `ACW_SIZE_32);
  wire postinc = cmd_word[`ACW_POSTINC_BIT];
  wire postexec = cmd_word[`ACW_POSTEXEC_BIT];
  wire xfer = cmd_word[`ACW_XFER_BIT];
  wire [15:0] regno = cmd_word[`ACW_REGNO_MSB:`ACW_REGNO_LSB];

  // Priority: option bits first, then size and register number
  always @* begin
    is_reg = 1'b0;
    is_mem = 1'b0;
    do_xfer = 1'b0;
    err_code = `ACW_ERR_NONE;
    case (kind)
      `ACW_KIND_REG: begin
        is_reg = 1'b1;
        do_xfer = xfer;
        if (postinc || postexec) begin
          // Checked even without transfer
          err_code = `ACW_ERR_NOTSUP;
        end else if (xfer && !size_ok) begin
          // Size is exempt while transfer is clear
          err_code = `ACW_ERR_NOTSUP;
        end else if (xfer && regno > `ACW_REGNO_GPR_HI) begin
          err_code = `ACW_ERR_NOTSUP;
        end
      end
      `ACW_KIND_MEM: begin
        is_mem = 1'b1;
        do_xfer = 1'b1;
        // Virtual bit and vendor bits are simply not looked at
        if (!size_ok || postinc) begin
          err_code = `ACW_ERR_NOTSUP;
        end
      end
      default: begin
        // Unknown kind: nothing moves
        err_code = `ACW_ERR_NOTSUP;
      end
    endcase
  end

endmodule // cmd_field_check
`default_nettype wire

// *** hdl/mem_range_check.v ***
// Address window check for the three core-local memory regions.
// Assumes each region is a power-of-two block aligned to its size.
`default_nettype none

module mem_range_check #(
  parameter [95:0] REGION_BASE = 96'hF008_0000_F004_0000_EE00_0000, // Per-region base, low word first
  parameter [95:0] REGION_MASK = 96'hFFF0_0000_FFFF_0000_FFFF_0000  // Per-region match mask
) (
  input wire [31:0] addr,          // Physical address
  output wire in_range,            // Address hits a local region
  output wire [2:0] region_hit     // Which region hit
);

  // One comparator per region
  genvar i;
  generate
    for (i = 0; i < 3; i = i + 1) begin : g_region
      assign region_hit[i] = ((addr & REGION_MASK[32*i+31:32*i]) == REGION_BASE[32*i+31:32*i]);
    end
  endgenerate

  assign in_range = |region_hit;

endmodule // mem_range_check
`default_nettype wire

// *** hdl/abs_cmd_decoder.v ***
// Abstract command decoder and executor for the debug module.
// Assumes a debug module interface giving one-cycle request strobes and a
// core that answers each register or memory request with a one-cycle ack.
// Inputs are taken as synchronous to clk, so no synchronisers stand here.
`default_nettype none
`include "abs_cmd_consts.vh"

module abs_cmd_decoder #(
  parameter [95:0] REGION_BASE = 96'hF008_0000_F004_0000_EE00_0000, // Local region bases
  parameter [95:0] REGION_MASK = 96'hFFF0_0000_FFFF_0000_FFFF_0000  // Local region masks
) (
  input wire clk,                   // Debug module clock
  input wire rst_b,                 // Asynchronous reset, active low
  input wire dmi_req,               // Interface request strobe
  input wire dmi_wr,                // 1 write, 0 read
  input wire [6:0] dmi_addr,        // Word offset
  input wire [31:0] dmi_wdata,      // Write data
  output reg dmi_ack,               // Answer valid, one cycle
  output reg [31:0] dmi_rdata,      // Read data
  output reg cmd_busy,              // Command executing
  output reg [2:0] cmd_err,         // Error code
  output reg [31:0] first_data_word,  // Data value
  output reg [31:0] second_data_word, // Memory address
  output reg core_reg_req,          // Register access request
  output reg core_reg_wr,           // Register access direction
  output reg core_reg_is_gpr,       // 1 GPR, 0 CSR
  output reg [11:0] core_reg_num,   // CSR number or GPR index
  output reg [31:0] core_reg_wdata, // Register write data
  input wire core_reg_ack,          // Register access done
  input wire [31:0] core_reg_rdata, // Register read data
  output reg core_mem_req,          // Memory access request
  output reg core_mem_wr,           // Memory access direction
  output reg [31:0] core_mem_addr,  // Memory address
  output reg [31:0] core_mem_wdata, // Memory write data
  input wire core_mem_ack,          // Memory access done
  input wire [31:0] core_mem_rdata  // Memory read data
);

  // One-hot states
  // One flip-flop per state keeps each state test a single bit, at the
  // price of one extra flop against a binary code.
  localparam [2:0] ST_IDLE = 3'b001;  // Waiting for a command
  localparam [2:0] ST_CHECK = 3'b010; // Judging latched word
  localparam [2:0] ST_WAIT = 3'b100;  // Waiting for the core

  // State and command storage
  reg [2:0] state_reg;        // Current state
  reg [31:0] cmd_word_reg;    // Latched command word
  reg [2:0] size_rd_reg;      // Readable size field
  reg xfer_rd_reg;            // Readable transfer field

  // Decoded view of the latched word
  // The checker sees the latched copy, so a debugger write in the check
  // cycle cannot change the verdict half way.
  wire dec_is_reg;
  wire dec_is_mem;
  wire dec_do_xfer;
  wire [2:0] dec_err;
  wire addr_ok;

  cmd_field_check u_check (
    .cmd_word(cmd_word_reg),
    .is_reg(dec_is_reg),
    .is_mem(dec_is_mem),
    .do_xfer(dec_do_xfer),
    .err_code(dec_err)
  );

  // Address window test on the second data word; it cannot change while
  // busy, so the verdict in the check cycle matches the address sent out.
  mem_range_check #(
    .REGION_BASE(REGION_BASE),
    .REGION_MASK(REGION_MASK)
  ) u_range (
    .addr(second_data_word),
    .in_range(addr_ok),
    .region_hit()
  );

  // Request decode
  // Each strobe lasts a single cycle, so these are one-cycle events too.
  wire wr_cmd = dmi_req && dmi_wr && (dmi_addr == `ACW_OFF_CMD);
  wire wr_cs = dmi_req && dmi_wr && (dmi_addr == `ACW_OFF_ABSCS);
  wire wr_d0 = dmi_req && dmi_wr && (dmi_addr == `ACW_OFF_FIRST_DATA_WORD);
  wire wr_d1 = dmi_req && dmi_wr && (dmi_addr == `ACW_OFF_SECOND_DATA_WORD);
  wire touch_data = dmi_req && ((dmi_addr == `ACW_OFF_FIRST_DATA_WORD) || (dmi_addr == `ACW_OFF_SECOND_DATA_WORD));

  // Accesses that collide with a running command
  // Reads of the data words count as well: their contents are in flux
  // while the core answers.
  wire collide = cmd_busy && (wr_cmd || wr_cs || touch_data);

  // A command starts only when idle and error free
  // A refused command does not touch the latch: the latch and readback keep
  // the last accepted word.
  wire launch = wr_cmd && !cmd_busy && (cmd_err == `ACW_ERR_NONE);

  // Hardware error event this cycle, zero if none
  // Several sources may want the error field in one cycle; this picks one.
  reg [2:0] hw_err;
  reg finish;                 // Command ends this cycle
  reg [2:0] state_next;

  // Next state and completion events
  // Field and address errors end the command in the check cycle, before
  // any request reaches the core, so a refused command never moves data.
  always @* begin
    hw_err = `ACW_ERR_NONE;
    finish = 1'b0;
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        // Only a clean write from idle moves on
        if (launch) begin
          state_next = ST_CHECK;
        end
      end
      ST_CHECK: begin
        if (dec_err != `ACW_ERR_NONE) begin
          // Field errors end the command at once
          hw_err = dec_err;
          finish = 1'b1;
          state_next = ST_IDLE;
        end else if (dec_is_mem && !addr_ok) begin
          hw_err = `ACW_ERR_EXCEPT;
          finish = 1'b1;
          state_next = ST_IDLE;
        end else if (!dec_do_xfer) begin
          // Clean register command without transfer
          finish = 1'b1;
          state_next = ST_IDLE;
        end else begin
          state_next = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // An ack counts only while our own request stands
        if ((core_reg_req && core_reg_ack) || (core_mem_req && core_mem_ack)) begin
          finish = 1'b1;
          state_next = ST_IDLE;
        end
      end
      default: begin
        // Illegal code: fall back to idle
        state_next = ST_IDLE;
      end
    endcase
    if (collide && cmd_err == `ACW_ERR_NONE && hw_err == `ACW_ERR_NONE) begin
      // Busy collision only lands on a clean error field
      hw_err = `ACW_ERR_BUSY;
    end
  end

  // State register
  // Reset returns to idle with no request outstanding
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Busy flag: raised on launch, dropped on completion
  // Launch and finish never share a cycle: finish needs busy, launch
  // needs it clear.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_busy <= 1'b0;
    end else if (launch) begin
      cmd_busy <= 1'b1;
    end else if (finish) begin
      cmd_busy <= 1'b0;
    end
  end

  // Error field: hardware set beats a same-cycle software clear
  // Letting the set win keeps a failure visible even if the debugger
  // clears the field in the very cycle the command fails.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_err <= `ACW_ERR_NONE;
    end else if (hw_err != `ACW_ERR_NONE) begin
      cmd_err <= hw_err;
    end else if (wr_cs) begin
      // Write one to clear, bit by bit
      cmd_err <= cmd_err & ~dmi_wdata[`ACW_CS_ERR_MSB:`ACW_CS_ERR_LSB];
    end
  end

  // Command latch and the fields that read back
  // The whole word is kept so the checker and the ports see one value
  // for the life of the command.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_word_reg <= 32'h0000_0000;
      size_rd_reg <= `ACW_SIZE_RST;
      xfer_rd_reg <= `ACW_XFER_RST;
    end else if (launch) begin
      cmd_word_reg <= dmi_wdata;
      size_rd_reg <= dmi_wdata[`ACW_SIZE_MSB:`ACW_SIZE_LSB];
      // Transfer only exists for register commands
      xfer_rd_reg <= (dmi_wdata[`ACW_KIND_MSB:`ACW_KIND_LSB] == `ACW_KIND_REG) ?
                     dmi_wdata[`ACW_XFER_BIT] : 1'b0;
    end
  end

  // First data word: debugger writes when idle, reads from the core land here
  // Core answers take priority; debugger writes while busy are dropped
  // here and flagged by the collision logic instead.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      first_data_word <= 32'h0000_0000;
    end else if (state_reg == ST_WAIT && core_reg_req && core_reg_ack && !core_reg_wr) begin
      first_data_word <= core_reg_rdata;
    end else if (state_reg == ST_WAIT && core_mem_req && core_mem_ack && !core_mem_wr) begin
      first_data_word <= core_mem_rdata;
    end else if (wr_d0 && !cmd_busy) begin
      first_data_word <= dmi_wdata;
    end
  end

  // Second data word carries the memory address
  // No auto-increment: the word keeps its value after each command
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      second_data_word <= 32'h0000_0000;
    end else if (wr_d1 && !cmd_busy) begin
      // Must be loaded before the memory command
      second_data_word <= dmi_wdata;
    end
  end

  // Register access port toward the core
  // Request stays high until the core acks; one request outstanding
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      core_reg_req <= 1'b0;
      core_reg_wr <= 1'b0;
      core_reg_is_gpr <= 1'b0;
      core_reg_num <= 12'h000;
      core_reg_wdata <= 32'h0000_0000;
    end else if (state_reg == ST_CHECK && state_next == ST_WAIT && dec_is_reg) begin
      core_reg_req <= 1'b1;
      core_reg_wr <= cmd_word_reg[`ACW_WRITE_BIT];
      // GPR window sets bit 12, its index sits in the low bits
      core_reg_is_gpr <= cmd_word_reg[`ACW_REGNO_GPR_BIT];
      core_reg_num <= cmd_word_reg[11:0];
      core_reg_wdata <= first_data_word;
    end else if (core_reg_ack) begin
      core_reg_req <= 1'b0;
    end
  end

  // Memory access port toward the core
  // Same handshake as the register port; only one of the two is used
  // per command.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      core_mem_req <= 1'b0;
      core_mem_wr <= 1'b0;
      core_mem_addr <= 32'h0000_0000;
      core_mem_wdata <= 32'h0000_0000;
    end else if (state_reg == ST_CHECK && state_next == ST_WAIT && dec_is_mem) begin
      core_mem_req <= 1'b1;
      core_mem_wr <= cmd_word_reg[`ACW_WRITE_BIT];
      // Used as a physical address, no translation
      core_mem_addr <= second_data_word;
      core_mem_wdata <= first_data_word;
    end else if (core_mem_ack) begin
      core_mem_req <= 1'b0;
    end
  end

  // Read mux: command word shows only size and transfer
  // Unmapped offsets read zero; the mux is sampled into the answer
  // register, so the output still comes from a flop.
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0000_0000;
    case (dmi_addr)
      `ACW_OFF_FIRST_DATA_WORD: begin
        rd_mux = first_data_word;
      end
      `ACW_OFF_SECOND_DATA_WORD: begin
        rd_mux = second_data_word;
      end
      `ACW_OFF_ABSCS: begin
        rd_mux[`ACW_CS_BUSY_BIT] = cmd_busy;
        rd_mux[`ACW_CS_ERR_MSB:`ACW_CS_ERR_LSB] = cmd_err;
        rd_mux[3:0] = `ACW_CS_DATACOUNT;
      end
      `ACW_OFF_CMD: begin
        // Kind, direction, register number, vendor bits all read zero
        rd_mux[`ACW_SIZE_MSB:`ACW_SIZE_LSB] = size_rd_reg;
        rd_mux[`ACW_XFER_BIT] = xfer_rd_reg;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // Answer one cycle after each request
  // Read data holds between reads; writes leave it alone
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dmi_ack <= 1'b0;
      dmi_rdata <= 32'h0000_0000;
    end else begin
      dmi_ack <= dmi_req;
      if (dmi_req && !dmi_wr) begin
        dmi_rdata <= rd_mux;
      end
    end
  end

endmodule // abs_cmd_decoder
`default_nettype wire

// *** verification/abs_cmd_checker.sv ***
// Port-level assertions for the abstract command decoder.
// Assumes it is bound to abs_cmd_decoder and sees only its ports.
`default_nettype none
module abs_cmd_checker (
  input wire logic clk, // Clock
  input wire logic rst_b, // Reset, low
  input wire logic dmi_req, // Request
  input wire logic dmi_wr, // Direction
  input wire logic [6:0] dmi_addr, // Offset
  input wire logic [31:0] dmi_wdata, // Write data
  input wire logic cmd_busy, // Busy
  input wire logic [2:0] cmd_err, // Error
  input wire logic [31:0] first_data_word, // Data
  input wire logic [31:0] second_data_word, // Address
  input wire logic core_reg_req, // Reg request
  input wire logic core_reg_wr, // Reg direction
  input wire logic core_reg_is_gpr, // GPR select
  input wire logic [11:0] core_reg_num, // Reg number
  input wire logic [31:0] core_reg_wdata, // Reg write data
  input wire logic core_reg_ack, // Reg done
  input wire logic [31:0] core_reg_rdata, // Reg read data
  input wire logic core_mem_req, // Mem request
  input wire logic [31:0] core_mem_addr // Mem address
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] cmd_q; // Last accepted command
  logic cwr; // Command word write
  logic acc; // Write that starts a command
  logic [7:0] kind; // Kind of incoming word
  assign cwr = dmi_req && dmi_wr && dmi_addr == 7'h17;
  assign acc = cwr && !cmd_busy && cmd_err == 3'h0;
  assign kind = dmi_wdata[31:24];
  // Keep the word, since the issue shows two cycles later
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) cmd_q <= 32'h0;
    else if (acc) cmd_q <= dmi_wdata;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Refusal: code 2 one cycle after busy, busy already gone
  sequence s_fail2;
    ##1 (cmd_err == 3'h2 && !cmd_busy);
  endsequence
  // No core traffic for three cycles
  sequence s_quiet;
    (!core_reg_req && !core_mem_req)[*3];
  endsequence
  AST_KIND_BAD: assert property (acc && kind != 8'h00 && kind != 8'h02 |=> s_quiet and s_fail2)
    else $error("unknown kind not refused");
  AST_POSTINC: assert property (acc && dmi_wdata[19] && (kind == 8'h00 || kind == 8'h02) |=> s_fail2)
    else $error("post-increment not refused");
  AST_POSTEXEC: assert property (acc && kind == 8'h00 && dmi_wdata[18] |=> s_fail2)
    else $error("post-exec not refused");
  AST_SIZE: assert property (acc && dmi_wdata[22:20] != 3'h2
    && (kind == 8'h02 || kind == 8'h00 && dmi_wdata[17]) |=> s_fail2)
    else $error("bad size not refused");
  AST_NO_XFER: assert property (acc && kind == 8'h00 && !dmi_wdata[17] |=> s_quiet)
    else $error("register moved without transfer");
  AST_VIRT: assert property (acc && kind == 8'h02 && dmi_wdata[23] && dmi_wdata[22:19] == 4'h4
    |=> ##1 cmd_err != 3'h2)
    else $error("virtual bit refused");
  AST_BUSY: assert property (cwr && cmd_busy && cmd_err == 3'h0 |=> cmd_err != 3'h0)
    else $error("busy write not flagged");
  AST_BLOCK: assert property (cwr && !cmd_busy && cmd_err != 3'h0
    |=> (!cmd_busy && !core_reg_req && !core_mem_req)[*2])
    else $error("command started under error");
  AST_REG_ISSUE: assert property (acc && kind == 8'h00 && dmi_wdata[22:17] == 6'h11
    && dmi_wdata[15:0] < 16'h1020 |=> ##1 (core_reg_req && core_reg_num == cmd_q[11:0]
    && core_reg_is_gpr == cmd_q[12] && core_reg_wr == cmd_q[16]))
    else $error("register access not issued");
  AST_REG_WDATA: assert property (core_reg_req && core_reg_wr |-> core_reg_wdata == first_data_word)
    else $error("register write data wrong");
  AST_REG_READ: assert property (core_reg_req && core_reg_ack && !core_reg_wr
    |=> first_data_word == $past(core_reg_rdata))
    else $error("register read not stored");
  AST_MEM_ADDR: assert property (core_mem_req |-> core_mem_addr == second_data_word)
    else $error("memory address wrong");
endmodule // abs_cmd_checker

bind abs_cmd_decoder abs_cmd_checker u_chk (.clk, .rst_b, .dmi_req, .dmi_wr, .dmi_addr, .dmi_wdata, .cmd_busy,
  .cmd_err, .first_data_word, .second_data_word, .core_reg_req, .core_reg_wr, .core_reg_is_gpr, .core_reg_num,
  .core_reg_wdata, .core_reg_ack, .core_reg_rdata, .core_mem_req, .core_mem_addr);
`default_nettype wire

// *** verification/core_model.sv ***
// Behavioural core: registers and local memory behind the decoder.
// Assumes one request at a time, held until its ack pulse.
`default_nettype none
module core_model (
  input wire logic clk, // Clock
  input wire logic rst_b, // Reset, low
  input wire logic slow, // Add wait cycles
  input wire logic core_reg_req, // Reg request
  input wire logic core_reg_wr, // Reg direction
  input wire logic core_reg_is_gpr, // GPR select
  input wire logic [11:0] core_reg_num, // Reg number
  input wire logic [31:0] core_reg_wdata, // Reg write data
  output logic core_reg_ack, // Reg done
  output logic [31:0] core_reg_rdata, // Reg read data
  input wire logic core_mem_req, // Mem request
  input wire logic core_mem_wr, // Mem direction
  input wire logic [31:0] core_mem_addr, // Mem address
  input wire logic [31:0] core_mem_wdata, // Mem write data
  output logic core_mem_ack, // Mem done
  output logic [31:0] core_mem_rdata // Mem read data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] regs [0:63]; // CSR slots low, GPRs high
  logic [31:0] mem [0:63]; // Word store
  logic [1:0] wcnt; // Wait counter
  // Answer after zero or three waits; read data goes stale off the ack
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wcnt <= 2'h0;
      core_reg_ack <= 1'b0;
      core_mem_ack <= 1'b0;
      core_reg_rdata <= 32'h0;
      core_mem_rdata <= 32'h0;
    end else begin
      core_reg_ack <= 1'b0;
      core_mem_ack <= 1'b0;
      core_reg_rdata <= ~core_reg_rdata; // Never hold a valid look
      core_mem_rdata <= ~core_mem_rdata;
      if ((core_reg_req || core_mem_req) && !core_reg_ack && !core_mem_ack) begin
        if (wcnt != (slow ? 2'h3 : 2'h0)) wcnt <= wcnt + 2'h1;
        else begin
          wcnt <= 2'h0;
          if (core_reg_req) begin
            core_reg_ack <= 1'b1;
            if (core_reg_wr) regs[{core_reg_is_gpr, core_reg_num[4:0]}] <= core_reg_wdata;
            else core_reg_rdata <= regs[{core_reg_is_gpr, core_reg_num[4:0]}];
          end else begin
            core_mem_ack <= 1'b1;
            if (core_mem_wr) mem[core_mem_addr[7:2]] <= core_mem_wdata;
            else core_mem_rdata <= mem[core_mem_addr[7:2]];
          end
        end
      end
    end
  end
endmodule // core_model
`default_nettype wire

// *** verification/tb.sv ***
// Self-checking bench for the abstract command decoder.
// Assumes the core model on the far side and the checker bound in.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0; // Clock
  logic rst_b = 1'b0; // Reset, low
  logic dmi_req = 1'b0; // Request
  logic dmi_wr = 1'b0; // Direction
  logic [6:0] dmi_addr = 7'h00; // Offset
  logic [31:0] dmi_wdata = 32'h0; // Write data
  logic slow = 1'b0; // Core waits
  wire dmi_ack, cmd_busy, core_reg_req, core_reg_wr, core_reg_is_gpr, core_reg_ack;
  wire core_mem_req, core_mem_wr, core_mem_ack;
  wire [2:0] cmd_err;
  wire [11:0] core_reg_num;
  wire [31:0] dmi_rdata, first_data_word, second_data_word, core_reg_wdata, core_reg_rdata;
  wire [31:0] core_mem_addr, core_mem_wdata, core_mem_rdata;
  int errors = 0; // Mismatches
  int n_checks = 0; // Comparisons
  int cycles = 0; // Hang guard
  int acks = 0; // Core accesses done
  logic [31:0] rd; // Last read data
  logic [31:0] bad [9] = '{32'h0032_1005, 32'h002A_1005, 32'h0026_1005, 32'h0024_1005, 32'h0022_1020,
    32'h0522_0000, 32'h0210_0000, 32'h0228_0000, 32'h0220_0000}; // Refused commands
  abs_cmd_decoder dut (.clk, .rst_b, .dmi_req, .dmi_wr, .dmi_addr, .dmi_wdata, .dmi_ack, .dmi_rdata,
    .cmd_busy, .cmd_err, .first_data_word, .second_data_word, .core_reg_req, .core_reg_wr, .core_reg_is_gpr,
    .core_reg_num, .core_reg_wdata, .core_reg_ack, .core_reg_rdata, .core_mem_req, .core_mem_wr,
    .core_mem_addr, .core_mem_wdata, .core_mem_ack, .core_mem_rdata);
  core_model u_core (.clk, .rst_b, .slow, .core_reg_req, .core_reg_wr, .core_reg_is_gpr, .core_reg_num,
    .core_reg_wdata, .core_reg_ack, .core_reg_rdata, .core_mem_req, .core_mem_wr, .core_mem_addr,
    .core_mem_wdata, .core_mem_ack, .core_mem_rdata);
  always #50 clk = ~clk;
  // Count core accesses and cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (core_reg_ack || core_mem_ack) acks++;
    if (cycles == 3000) begin
      errors++;
      close_out();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One access: strobe for one cycle, answer lands with the ack
  task automatic acc(input logic wr, input logic [6:0] a, input logic [31:0] d);
    @(posedge clk);
    #1;
    dmi_req = 1'b1;
    dmi_wr = wr;
    dmi_addr = a;
    dmi_wdata = d;
    @(posedge clk);
    #1;
    dmi_req = 1'b0;
    chk({31'h0, dmi_ack}, 32'h1);
    rd = dmi_rdata;
  endtask
  // Write a command, wait until idle, then check the error code
  task automatic run(input logic [31:0] w, input logic [2:0] e);
    int n;
    acc(1'b1, 7'h17, w);
    for (n = 0; n < 40 && cmd_busy !== 1'b0; n++) @(posedge clk);
    #1;
    acc(1'b0, 7'h16, 32'h0);
    chk(rd[10:8], e);
  endtask
  task automatic close_out();
    if (errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    int n;
    repeat (8) @(posedge clk);
    #1;
    rst_b = 1'b1;
    acc(1'b0, 7'h17, 32'h0);
    chk(rd, 32'h0022_0000);
    // GPR fast, then CSR with a slow core
    for (int k = 0; k < 2; k++) begin
      slow = k[0];
      acc(1'b1, 7'h04, 32'h1234_5678 + k);
      run(k ? 32'h0023_0300 : 32'h0023_1005, 3'h0);
      chk(u_core.regs[k ? 0 : 37], 32'h1234_5678 + k);
      acc(1'b1, 7'h04, 32'h0);
      run(k ? 32'h0022_0300 : 32'h0022_1005, 3'h0);
      chk(first_data_word, 32'h1234_5678 + k);
    end
    n = acks;
    run(32'h0030_1005, 3'h0);
    chk(acks, n);
    // Memory write with virtual and vendor bits, then read back
    acc(1'b1, 7'h05, 32'hF004_0010);
    acc(1'b1, 7'h04, 32'hCAFE_F00D);
    run(32'h02A1_C000, 3'h0);
    chk(u_core.mem[4], 32'hCAFE_F00D);
    acc(1'b0, 7'h05, 32'h0);
    chk(rd, 32'hF004_0010);
    acc(1'b0, 7'h17, 32'h0);
    chk(rd, 32'h0020_0000);
    acc(1'b1, 7'h04, 32'h0);
    run(32'h0220_0000, 3'h0);
    chk(first_data_word, 32'hCAFE_F00D);
    // Each refusal, then a clean command that must stay blocked
    acc(1'b1, 7'h05, 32'h1000_0000);
    foreach (bad[i]) begin
      n = acks;
      run(bad[i], i == 8 ? 3'h3 : 3'h2);
      run(32'h0022_1005, i == 8 ? 3'h3 : 3'h2);
      chk(acks, n);
      acc(1'b1, 7'h16, 32'h0000_0700);
    end
    // Second command while the slow core is still busy
    slow = 1'b1;
    acc(1'b1, 7'h17, 32'h0022_1005);
    run(32'h0022_1005, 3'h1);
    close_out();
  end
endmodule // tb
`default_nettype wire
